// ==== core/special_function_regs.v ====
// What this block does
// - Bank sits in lowest special-function address range
// - Unassigned bits hold no storage
// - Plain reset bits restored by system reset
// - Parenthesised reset bits restored only at power-on
// - Enable one: tx, rx, flash, nmi, osc, watchdog
// - Watchdog enable acts only in interval mode
// - Enable two holds only basic tick enable
// - Flag one: tx, rx, nmi, osc, watchdog
// - Serial tx flag resets one, rx zero
// - Pin NMI event sets its flag
// - Oscillator fault sets flag; resets to one
// - Watchdog overflow or bad key sets flag
// - Watchdog flag cleared by power-on or pin reset
// - Flag two holds only basic tick flag
// - Module enable one: async tx at bit 7
// - Bit 6: async rx or sync tx/rx enable
// - No second module enable register
// - Non-maskable sources gated only per source
`timescale 1ns/1ps
`include "sfr_regs.vh"

module special_function_regs (
  // Clock, power-on reset and software-visible system reset
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        system_reset,
  // Classic Wishbone slave; the register byte always rides the low lane
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Set events from the peripherals; each high cycle sets
  input  wire        serial_tx_set,
  input  wire        serial_rx_set,
  input  wire        pin_nmi_set,
  input  wire        osc_fault_set,
  input  wire        watchdog_overflow,
  input  wire        watchdog_key_bad,
  // Mode levels, pin reset clear, basic tick set and the flag kept in the flash controller
  input  wire        watchdog_interval_mode,
  input  wire        pin_reset_clear,
  input  wire        basic_tick_set,
  input  wire        flash_violation_pending,
  input  wire        serial_sync_mode,
  // Requests to the processor, one per source
  output wire        serial_tx_irq,
  output wire        serial_rx_irq,
  output wire        flash_violation_irq,
  output wire        pin_nmi_irq,
  output wire        osc_fault_irq,
  output wire        watchdog_irq,
  output wire        basic_tick_irq,
  // Serial module enables
  output wire        async_tx_module_en,
  output wire        async_rx_module_en,
  output wire        sync_txrx_module_en
);

  // Stored register images; absent bits are constant zero
  wire [7:0] int_en_one_r;
  wire [7:0] int_en_two_r;
  wire [7:0] int_flag_one_r;
  wire [7:0] int_flag_two_r;
  wire [7:0] mod_en_one_r;

  // Bus decode
  wire       req;
  wire       in_window;
  wire [3:0] idx;
  wire       wr_byte;
  reg        wr_en_one;
  reg        wr_en_two;
  reg        wr_flag_one;
  reg        wr_flag_two;
  reg        wr_mod_one;
  wire [7:0] wdata;
  reg  [7:0] rd_byte;

  // Hardware set vectors, one bit per flag position
  wire [7:0] set_flag_one;
  wire [7:0] set_flag_two;

  // Reset values as indexable constants, one bit per flop
  localparam [7:0] RST_EN_ONE    = `RST_INT_EN_ONE;
  localparam [7:0] RST_EN_TWO    = `RST_INT_EN_TWO;
  localparam [7:0] RST_FLAG_ONE  = `RST_INT_FLAG_ONE;
  localparam [7:0] RST_FLAG_TWO  = `RST_INT_FLAG_TWO;
  localparam [7:0] RST_MOD_ONE   = `RST_MOD_EN_ONE;

  // Which positions hold storage at all
  localparam [7:0] MASK_EN_ONE   = `MASK_INT_EN_ONE;
  localparam [7:0] MASK_EN_TWO   = `MASK_INT_EN_TWO;
  localparam [7:0] MASK_FLAG_ONE = `MASK_INT_FLAG_ONE;
  localparam [7:0] MASK_FLAG_TWO = `MASK_INT_FLAG_TWO;
  localparam [7:0] MASK_MOD_ONE  = `MASK_MOD_EN_ONE;

  // Flag bits that the system reset must leave alone
  localparam [7:0] POR_ONLY_ONE  = `POR_ONLY_FLAG_ONE;

  // New request only while no answer is standing
  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  // One register per byte address; data always on the low lane
  assign idx       = wb_adr_i[3:0];
  // From 10h up lies the 8-bit peripheral range, refused here
  assign in_window = (wb_adr_i[7:4] == 4'h0) & (idx <= `SFR_WINDOW_TOP);
  assign wr_byte   = req & in_window & wb_we_i & wb_sel_i[0];
  assign wdata     = wb_dat_i[7:0];

  // Per-register write strobes; no strobe exists for a second module enable
  always @* begin
    wr_en_one   = 1'b0;
    wr_en_two   = 1'b0;
    wr_flag_one = 1'b0;
    wr_flag_two = 1'b0;
    wr_mod_one  = 1'b0;
    case (idx)
      `IDX_INT_EN_ONE:   wr_en_one   = wr_byte;
      `IDX_INT_EN_TWO:   wr_en_two   = wr_byte;
      `IDX_INT_FLAG_ONE: wr_flag_one = wr_byte;
      `IDX_INT_FLAG_TWO: wr_flag_two = wr_byte;
      `IDX_MOD_EN_ONE:   wr_mod_one  = wr_byte;
      // Free addresses are acknowledged, the write dropped
      default:           wr_mod_one  = 1'b0;
    endcase
  end

  // Watchdog flag takes both overflow and bad-key events
  assign set_flag_one = {serial_tx_set,
                         serial_rx_set,
                         1'b0,
                         pin_nmi_set,
                         2'b00,
                         osc_fault_set,
                         watchdog_overflow | watchdog_key_bad};
  assign set_flag_two = {basic_tick_set, 7'h00};

  // One loop per register; absent positions become constant zero
  genvar i;

  // Interrupt enable one: six bits, positions 3 and 2 absent
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_en_one
      if (MASK_EN_ONE[i]) begin : g_ie1
        reg bit_r;
        always @(posedge mclk or posedge sys_rst) begin
          if (sys_rst) begin
            bit_r <= RST_EN_ONE[i];
          end else if (system_reset) begin
            bit_r <= RST_EN_ONE[i];
          end else if (wr_en_one) begin
            bit_r <= wdata[i];
          end
        end
        assign int_en_one_r[i] = bit_r;
      end else begin : g_ie1_none
        assign int_en_one_r[i] = 1'b0;
      end
    end
  endgenerate

  // Interrupt enable two: only the basic tick enable exists
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_en_two
      if (MASK_EN_TWO[i]) begin : g_ie2
        reg bit_r;
        always @(posedge mclk or posedge sys_rst) begin
          if (sys_rst) begin
            bit_r <= RST_EN_TWO[i];
          end else if (system_reset) begin
            bit_r <= RST_EN_TWO[i];
          end else if (wr_en_two) begin
            bit_r <= wdata[i];
          end
        end
        assign int_en_two_r[i] = bit_r;
      end else begin : g_ie2_none
        assign int_en_two_r[i] = 1'b0;
      end
    end
  endgenerate

  // Module enable one: transmit and receive enables only
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_mod_one
      if (MASK_MOD_ONE[i]) begin : g_me1
        reg bit_r;
        always @(posedge mclk or posedge sys_rst) begin
          if (sys_rst) begin
            bit_r <= RST_MOD_ONE[i];
          end else if (system_reset) begin
            bit_r <= RST_MOD_ONE[i];
          end else if (wr_mod_one) begin
            bit_r <= wdata[i];
          end
        end
        assign mod_en_one_r[i] = bit_r;
      end else begin : g_me1_none
        assign mod_en_one_r[i] = 1'b0;
      end
    end
  endgenerate

  // Flag one: a hardware set beats a write in the same cycle, so an
  // event is never lost to a clearing write; system reset beats both,
  // except on the watchdog bit, which must survive to name the cause
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag_one
      if (MASK_FLAG_ONE[i]) begin : g_if1
        reg bit_r;
        if (POR_ONLY_ONE[i]) begin : g_por
          // Survives system reset so software can see the cause
          always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
              bit_r <= RST_FLAG_ONE[i];
            end else if (pin_reset_clear) begin
              bit_r <= 1'b0;
            end else if (set_flag_one[i]) begin
              bit_r <= 1'b1;
            end else if (wr_flag_one) begin
              bit_r <= wdata[i];
            end
          end
        end else begin : g_puc
          always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
              bit_r <= RST_FLAG_ONE[i];
            end else if (system_reset) begin
              bit_r <= RST_FLAG_ONE[i];
            end else if (set_flag_one[i]) begin
              bit_r <= 1'b1;
            end else if (wr_flag_one) begin
              bit_r <= wdata[i];
            end
          end
        end
        assign int_flag_one_r[i] = bit_r;
      end else begin : g_if1_none
        assign int_flag_one_r[i] = 1'b0;
      end
    end
  endgenerate

  // Flag two: only the basic tick flag exists
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag_two
      if (MASK_FLAG_TWO[i]) begin : g_if2
        reg bit_r;
        always @(posedge mclk or posedge sys_rst) begin
          if (sys_rst) begin
            bit_r <= RST_FLAG_TWO[i];
          end else if (system_reset) begin
            bit_r <= RST_FLAG_TWO[i];
          end else if (set_flag_two[i]) begin
            bit_r <= 1'b1;
          end else if (wr_flag_two) begin
            bit_r <= wdata[i];
          end
        end
        assign int_flag_two_r[i] = bit_r;
      end else begin : g_if2_none
        assign int_flag_two_r[i] = 1'b0;
      end
    end
  endgenerate

  // Read mux; anything not mapped reads as zero
  always @* begin
    case (idx)
      `IDX_INT_EN_ONE:   rd_byte = int_en_one_r;
      `IDX_INT_EN_TWO:   rd_byte = int_en_two_r;
      `IDX_INT_FLAG_ONE: rd_byte = int_flag_one_r;
      `IDX_INT_FLAG_TWO: rd_byte = int_flag_two_r;
      `IDX_MOD_EN_ONE:   rd_byte = mod_en_one_r;
      default:           rd_byte = 8'h00;
    endcase
  end

  // Single-wait-state answer; ack drops the cycle after it rose.
  // The standing ack masks req, so a held request is not taken twice.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & in_window;
    end
  end

  // Outside the window: err, with no effect on any register
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req & ~in_window;
    end
  end

  // Read data registered; zero for writes and refused cycles.
  // It holds after the answer so a slow master still finds it.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      if (req & in_window & ~wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end else if (req) begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Interrupt requests: flag and enable; no global enable enters here
  assign serial_tx_irq =
    int_flag_one_r[`BIT_SERIAL_TX] & int_en_one_r[`BIT_SERIAL_TX];
  assign serial_rx_irq =
    int_flag_one_r[`BIT_SERIAL_RX] & int_en_one_r[`BIT_SERIAL_RX];
  // Flash flag lives in the flash controller; only its enable is here
  assign flash_violation_irq =
    flash_violation_pending & int_en_one_r[`BIT_FLASH_VIOL];
  assign pin_nmi_irq =
    int_flag_one_r[`BIT_PIN_NMI] & int_en_one_r[`BIT_PIN_NMI];
  assign osc_fault_irq =
    int_flag_one_r[`BIT_OSC_FAULT] & int_en_one_r[`BIT_OSC_FAULT];
  // In watchdog mode the flag means reset cause, never an interrupt
  assign watchdog_irq = watchdog_interval_mode &
    int_flag_one_r[`BIT_WATCHDOG] & int_en_one_r[`BIT_WATCHDOG];
  assign basic_tick_irq =
    int_flag_two_r[`BIT_BASIC_TICK] & int_en_two_r[`BIT_BASIC_TICK];

  // Serial module enables; bit 6 changes meaning with the serial mode
  assign async_tx_module_en  = mod_en_one_r[`BIT_ASYNC_TX_EN];
  assign async_rx_module_en  = ~serial_sync_mode & mod_en_one_r[`BIT_RX_EN];
  assign sync_txrx_module_en = serial_sync_mode & mod_en_one_r[`BIT_RX_EN];

endmodule // special_function_regs

// ==== shared/sfr_regs.vh ====
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// Register byte addresses inside the special-function window
`define IDX_INT_EN_ONE    4'h0
`define IDX_INT_EN_TWO    4'h1
`define IDX_INT_FLAG_ONE  4'h2
`define IDX_INT_FLAG_TWO  4'h3
`define IDX_MOD_EN_ONE    4'h4

// Special-function window: indices 0h..Fh, below the 8-bit peripherals
`define SFR_WINDOW_TOP    4'hf

// Field positions
`define BIT_SERIAL_TX     3'd7
`define BIT_SERIAL_RX     3'd6
`define BIT_FLASH_VIOL    3'd5
`define BIT_PIN_NMI       3'd4
`define BIT_OSC_FAULT     3'd1
`define BIT_WATCHDOG      3'd0
`define BIT_BASIC_TICK    3'd7
`define BIT_ASYNC_TX_EN   3'd7
`define BIT_RX_EN         3'd6

// Implemented-bit masks
`define MASK_INT_EN_ONE   8'hf3
`define MASK_INT_EN_TWO   8'h80
`define MASK_INT_FLAG_ONE 8'hd3
`define MASK_INT_FLAG_TWO 8'h80
`define MASK_MOD_EN_ONE   8'hc0

// Reset values
`define RST_INT_EN_ONE    8'h00
`define RST_INT_EN_TWO    8'h00
`define RST_INT_FLAG_ONE  8'h82
`define RST_INT_FLAG_TWO  8'h00
`define RST_MOD_EN_ONE    8'h00

// Flag bits that only power-on reset restores
`define POR_ONLY_FLAG_ONE 8'h01

`endif

// ==== verification/sfr_checker_asserts.sv ====
`timescale 1ns/1ps
// Watches the bank's bus and request outputs
module sfr_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        system_reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        watchdog_interval_mode,
  input wire logic        flash_violation_pending,
  input wire logic        serial_sync_mode,
  input wire logic        serial_tx_irq,
  input wire logic        serial_rx_irq,
  input wire logic        flash_violation_irq,
  input wire logic        pin_nmi_irq,
  input wire logic        osc_fault_irq,
  input wire logic        watchdog_irq,
  input wire logic        async_tx_module_en,
  input wire logic        async_rx_module_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // A request not yet answered
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_outside;
    s_take ##0 (wb_adr_i[7:4] != 4'h0);
  endsequence
  AST_ANSWER: assert property (s_take |=> (wb_ack_o ^ wb_err_o))
    else $error("request not answered once");
  AST_ERR_OUT: assert property (s_outside |=> wb_err_o)
    else $error("outside address not refused");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("absent read bits not zero");
  AST_ERR_DATA: assert property (wb_err_o |-> wb_dat_o == 32'h0)
    else $error("refused access returned data");
  AST_WD_MODE: assert property (watchdog_irq |-> watchdog_interval_mode)
    else $error("watchdog request in watchdog mode");
  AST_FLASH: assert property (flash_violation_irq |-> flash_violation_pending)
    else $error("flash request without pending");
  AST_SYNC: assert property (serial_sync_mode |-> !async_rx_module_en)
    else $error("async rx enable in sync mode");
  AST_SYSRST: assert property (system_reset |=> !(serial_tx_irq || serial_rx_irq ||
    pin_nmi_irq || osc_fault_irq || flash_violation_irq || async_tx_module_en))
    else $error("system reset left enables set");
endmodule // sfr_checker

bind special_function_regs sfr_checker chk_inst (.*);

// ==== verification/wb_master.sv ====
`timescale 1ns/1ps
// Bus master in the place of the processor
module wb_master (
  input  wire logic        mclk,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic [7:0]       wb_adr_i,
  output logic [3:0]       wb_sel_i,
  output logic [31:0]      wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        wb_err_o
);
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // Holds everything until the answering edge; latency never assumed
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h0, d};
    do @(posedge mclk); while (!(wb_ack_o || wb_err_o));
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
endmodule // wb_master

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, x, s) begin compares++; if ((s) !== (x)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, x, s); end end
module tb_top;
  typedef struct {logic we; logic [7:0] a, d, x;} row_t;
  logic mclk = 0, sys_rst = 1, system_reset = 0, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic wb_ack_o, wb_err_o, e, serial_tx_set = 0, serial_rx_set = 0, pin_nmi_set = 0;
  logic osc_fault_set = 0, watchdog_overflow = 0, watchdog_key_bad = 0, basic_tick_set = 0;
  logic watchdog_interval_mode = 0, pin_reset_clear = 0, flash_violation_pending = 0;
  logic serial_sync_mode = 0, serial_tx_irq, serial_rx_irq, flash_violation_irq;
  logic pin_nmi_irq, osc_fault_irq, watchdog_irq, basic_tick_irq;
  logic async_tx_module_en, async_rx_module_en, sync_txrx_module_en;
  int fail_count = 0, compares = 0, cycles = 0;
  // Reset values, then each register written full and read back
  row_t rows [18] = '{'{0,8'h00,0,8'h00}, '{0,8'h01,0,8'h00}, '{0,8'h02,0,8'h82},
    '{0,8'h03,0,8'h00}, '{0,8'h04,0,8'h00}, '{1,8'h00,8'hff,0}, '{0,8'h00,0,8'hf3},
    '{1,8'h01,8'hff,0}, '{0,8'h01,0,8'h80}, '{1,8'h02,8'hff,0}, '{0,8'h02,0,8'hd3},
    '{1,8'h03,8'hff,0}, '{0,8'h03,0,8'h80}, '{1,8'h04,8'hff,0}, '{0,8'h04,0,8'hc0},
    '{1,8'h05,8'hff,0}, '{0,8'h05,0,8'h00}, '{1,8'h02,8'h00,0}};
  special_function_regs special_function_regs_inst (.*);
  wb_master wb_master_inst (.*);
  always #20 mclk = ~mclk;
  task give_verdict;
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cut a hang short well past the expected hundred-odd cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict;
    end
  end
  task rd(input logic [7:0] a, input logic [7:0] x);
    wb_master_inst.xfer(1'b0, a, 8'h00, q, e);
    `CHK("rdata", {24'h0, x}, q)
  endtask
  task settle;
    @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wb_master_inst.xfer(rows[i].we, rows[i].a, rows[i].d, q, e);
      if (!rows[i].we) `CHK("row", {24'h0, rows[i].x}, q)
    end
    // Sources set while enables are on
    @(posedge mclk) {pin_nmi_set, osc_fault_set, watchdog_overflow} <= 3'h7;
    @(posedge mclk) {pin_nmi_set, osc_fault_set, watchdog_overflow} <= 3'h0;
    settle;
    `CHK("nmi", 1'b1, pin_nmi_irq)
    `CHK("osc", 1'b1, osc_fault_irq)
    `CHK("wdog", 1'b0, watchdog_irq)
    `CHK("tick", 1'b1, basic_tick_irq)
    @(posedge mclk) {watchdog_interval_mode, flash_violation_pending, serial_sync_mode} <= 3'h7;
    settle;
    `CHK("wdog", 1'b1, watchdog_irq)
    `CHK("flash", 1'b1, flash_violation_irq)
    `CHK("sync", 1'b1, sync_txrx_module_en)
    `CHK("atx", 1'b1, async_tx_module_en)
    `CHK("arx", 1'b0, async_rx_module_en)
    // Hardware set beats a clearing write: sets stand only at the taking edge
    fork
      wb_master_inst.xfer(1'b1, 8'h02, 8'h01, q, e);
      begin
        @(posedge mclk) {serial_tx_set, serial_rx_set} <= 2'h3;
        @(posedge mclk) {serial_tx_set, serial_rx_set} <= 2'h0;
      end
    join
    rd(8'h02, 8'hc1);
    `CHK("txirq", 1'b1, serial_tx_irq)
    `CHK("rxirq", 1'b1, serial_rx_irq)
    @(posedge mclk) {serial_tx_set, serial_rx_set, system_reset} <= 3'h1;
    @(posedge mclk) system_reset <= 1'b0;
    rd(8'h02, 8'h83);
    rd(8'h00, 8'h00);
    @(posedge mclk) pin_reset_clear <= 1'b1;
    @(posedge mclk) pin_reset_clear <= 1'b0;
    rd(8'h02, 8'h82);
    @(posedge mclk) watchdog_key_bad <= 1'b1;
    @(posedge mclk) watchdog_key_bad <= 1'b0;
    rd(8'h02, 8'h83);
    @(posedge mclk) sys_rst <= 1'b1;
    @(posedge mclk) sys_rst <= 1'b0;
    rd(8'h02, 8'h82);
    wb_master_inst.xfer(1'b0, 8'h40, 8'h00, q, e);
    `CHK("err", 1'b1, e)
    give_verdict;
  end
endmodule // tb_top
